//--- occ_pkg.sv
// Overview of operation
// - Eight clock modes from 3-bit field
// - External clock mode: pin in, out free
// - RC mode drives RC clock over four
// - RC IO mode: out pin is I/O
// - Internal divided_clock_output mode: system clock over four
// - Internal IO mode frees both pins
// - Crystal modes count 1024 input cycles
// - Execution halted while counter runs, unless two-speed start-up is on
// - No start-up count in external clock
// - Static logic: stopped clock keeps state
// - Frequency field resets to 110
// - Bit 3 shows configured source running
// - Start-up status reset value follows config
// - Bit 2 shows high oscillator stable
// - Bit 1 shows low oscillator stable
// - Bit 0 selects internal or configured
// - Bit 7 reads zero
// - Fail-safe falls back to internal
// - Switch delays per target source
// - Two internal oscillators, high and low
// - Crystal modes set amplifier gain
// - Reset clears system clock select
// - Switch waits low, joins at rise
package occ_pkg;
  // ---------------------------------------------
  // Register map
  // ---------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam int         BIT_SCS  = 0;
  localparam int         BIT_LTS  = 1;
  localparam int         BIT_HTS  = 2;
  localparam int         BIT_STARTUP_TIMEOUT_STATUS = 3;
  localparam int         FRQ_LO   = 4;
  localparam logic [2:0] FRQ_RST  = 3'h6;
  localparam logic [2:0] FRQ_LF   = 3'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  // ---------------------------------------------
  // Clock modes and sources
  // ---------------------------------------------
  typedef enum logic [2:0] {
    MODE_EXT   = 3'h0,
    MODE_LOWX  = 3'h1,
    MODE_MIDX  = 3'h2,
    MODE_HIGHX = 3'h3,
    MODE_RC    = 3'h4,
    MODE_RC_NETWORK_IO_MODE  = 3'h5,
    MODE_INTCK = 3'h6,
    MODE_INTIO = 3'h7
  } occ_mode_t;
  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_HF  = 2'h1,
    SRC_LF  = 2'h2
  } occ_src_t;
  typedef enum logic [2:0] {
    SW_RUN  = 3'b001,
    SW_LOW  = 3'b010,
    SW_NEW  = 3'b100
  } occ_sw_t;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int STARTUP_EDGES = 1024;
  localparam int EXT_POR_EDGES = 2;
  localparam int EXT_LF_EDGES  = 1;
  localparam int HF_SWITCH_NS  = 1000;
  localparam int HF_SWITCH_CYC =
    (HF_SWITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
endpackage

//--- occ_top.sv
`timescale 1ns/10ps
module occ_top #(
  parameter int LF_HALF_CYC = 161,
  parameter int HF_HALF_CYC = 1,
  parameter int WARM_CYC    = 8,
  parameter int FAIL_CYC    = 4096
) (
  input  wire logic             I_CLK,
  input  wire logic             I_RST_N,
  input  wire occ_pkg::occ_mode_t I_CLK_MODE,
  input  wire logic             I_TWO_SPEED_EN,
  input  wire logic             I_FAIL_SAFE_EN,
  input  wire logic             I_POWER_UP_TIMER_EN,
  input  wire logic             I_POWER_UP_TIMER_DONE,
  input  wire logic             I_WAKE,
  input  wire logic             I_OSC_IN,
  output logic                  O_OSC_OUT,
  output logic                  O_OSC_OUT_OE,
  output logic                  O_OSC_IN_GPIO,
  output logic                  O_OSC_OUT_GPIO,
  output logic [1:0]            O_AMP_GAIN,
  output logic                  O_SYS_CLK,
  output logic                  O_SYS_CLK_EN,
  output logic                  O_CPU_RUN,
  input  wire logic [3:0]       S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  input  wire logic [3:0]       S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY
);
  import occ_pkg::*;

  // ---------------------------------------------
  // Pin synchroniser and edges
  // ---------------------------------------------
  logic       pin_s1_reg;
  logic       pin_s2_reg;
  logic       pin_d_reg;
  logic       ext_rise;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= I_OSC_IN;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end
  assign ext_rise = pin_s2_reg & ~pin_d_reg;

  // ---------------------------------------------
  // Mode decode
  // ---------------------------------------------
  wire crystal  = (I_CLK_MODE == MODE_LOWX) | (I_CLK_MODE == MODE_MIDX) |
                  (I_CLK_MODE == MODE_HIGHX);
  wire int_mode = (I_CLK_MODE == MODE_INTCK) |
                  (I_CLK_MODE == MODE_INTIO);
  wire ext_mode = ~int_mode;

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [2:0] frq_reg;
  logic       scs_reg;
  logic       fail_reg;
  logic       boot_reg;

  // ---------------------------------------------
  // Internal oscillators
  // ---------------------------------------------
  logic [8:0] lf_cnt_reg;
  logic       lf_lvl_reg;
  logic [3:0] hf_cnt_reg;
  logic       hf_lvl_reg;
  logic [6:0] post_reg;
  logic [3:0] hf_warm_reg;
  logic [3:0] lf_warm_reg;
  occ_src_t   cur_reg;
  occ_src_t   tgt_src;
  logic       busy_reg;
  wire int_sel  = scs_reg | fail_reg | int_mode |
                  (busy_reg & I_TWO_SPEED_EN & crystal);
  wire [1:0] int_src = (frq_reg == FRQ_LF) ? SRC_LF : SRC_HF;
  assign tgt_src = int_sel ? occ_src_t'(int_src) : SRC_EXT;
  wire hf_on    = (tgt_src == SRC_HF) | (cur_reg == SRC_HF);
  wire lf_on    = (tgt_src == SRC_LF) | (cur_reg == SRC_LF) |
                  I_FAIL_SAFE_EN | I_POWER_UP_TIMER_EN;
  wire hf_stab  = hf_on & (hf_warm_reg == 4'(WARM_CYC));
  wire lf_stab  = lf_on & (lf_warm_reg == 4'(WARM_CYC));
  wire lf_wrap  = (lf_cnt_reg == 9'(LF_HALF_CYC - 1));
  wire hf_wrap  = (hf_cnt_reg == 4'(HF_HALF_CYC - 1));
  wire hf_rise  = hf_wrap & ~hf_lvl_reg;
  // Postscaler: field 111 is the base, each step down halves
  wire [7:0] post_taps = {post_reg, hf_lvl_reg};
  wire       hf_level  = post_taps[3'h7 - frq_reg];

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lf_cnt_reg <= '0;
      lf_lvl_reg <= 1'b0;
      hf_cnt_reg <= '0;
      hf_lvl_reg <= 1'b0;
      post_reg   <= '0;
    end else begin
      lf_cnt_reg <= (lf_wrap | ~lf_on) ? '0 : lf_cnt_reg + 9'h001;
      lf_lvl_reg <= lf_on & (lf_lvl_reg ^ lf_wrap);
      hf_cnt_reg <= (hf_wrap | ~hf_on) ? '0 : hf_cnt_reg + 4'h1;
      hf_lvl_reg <= hf_on & (hf_lvl_reg ^ hf_wrap);
      if (hf_rise) begin
        post_reg <= post_reg - 7'h01;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hf_warm_reg <= '0;
      lf_warm_reg <= '0;
    end else begin
      hf_warm_reg <= !hf_on ? '0 : hf_warm_reg + 4'(!hf_stab);
      lf_warm_reg <= !lf_on ? '0 : lf_warm_reg + 4'(!lf_stab);
    end
  end

  // ---------------------------------------------
  // Start-up counter
  // ---------------------------------------------
  logic [10:0] st_cnt_reg;
  logic        por_reg;
  wire st_go   = crystal & ((por_reg & ~I_POWER_UP_TIMER_EN) |
                 (I_POWER_UP_TIMER_EN & I_POWER_UP_TIMER_DONE) | I_WAKE);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      por_reg    <= 1'b1;
      busy_reg   <= 1'b0;
      st_cnt_reg <= '0;
    end else begin
      por_reg <= 1'b0;
      if (st_go) begin
        busy_reg   <= 1'b1;
        st_cnt_reg <= '0;
      end else if (busy_reg & ext_rise) begin
        st_cnt_reg <= st_cnt_reg + 11'h001;
        busy_reg   <= (st_cnt_reg != 11'(STARTUP_EDGES - 1));
      end
      if (!crystal) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Fail-safe monitor
  // ---------------------------------------------
  logic [12:0] fs_cnt_reg;
  wire fs_watch = I_FAIL_SAFE_EN & ext_mode & (cur_reg == SRC_EXT);
  wire fs_trip  = fs_watch & (fs_cnt_reg == 13'(FAIL_CYC - 1));
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fs_cnt_reg <= '0;
    end else begin
      fs_cnt_reg <= (!fs_watch | ext_rise | fs_trip) ? '0 :
                    fs_cnt_reg + 13'h0001;
    end
  end

  // ---------------------------------------------
  // Clock switch sequencer
  // ---------------------------------------------
  occ_sw_t     sw_reg;
  logic [3:0]  dly_reg;
  logic        sys_reg;
  logic        from_por_reg;
  logic        src_lvl;
  logic        tgt_lvl;
  logic        tgt_rise;
  logic        tgt_prev_reg;
  always_comb begin
    case (cur_reg)
      SRC_HF:  src_lvl = hf_level;
      SRC_LF:  src_lvl = lf_lvl_reg;
      default: src_lvl = pin_s2_reg;
    endcase
    case (tgt_src)
      SRC_HF:  tgt_lvl = hf_level;
      SRC_LF:  tgt_lvl = lf_lvl_reg;
      default: tgt_lvl = pin_s2_reg;
    endcase
  end
  assign tgt_rise = tgt_lvl & ~tgt_prev_reg;
  wire tgt_ok    = (tgt_src == SRC_EXT) |
                   ((tgt_src == SRC_HF) ? hf_stab : lf_stab);
  // Delay count for the new source: HF counts I_CLK cycles, others their own rising edges
  wire [3:0] dly_init =
    (tgt_src == SRC_HF)  ? 4'(HF_SWITCH_CYC) :
    (tgt_src == SRC_EXT & ~from_por_reg & cur_reg == SRC_LF) ?
                           4'(EXT_LF_EDGES) :
    (tgt_src == SRC_EXT) ? 4'(EXT_POR_EDGES) : 4'h1;
  wire dly_step  = (tgt_src == SRC_HF) ? 1'b1 : tgt_rise;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sw_reg       <= SW_LOW;
      cur_reg      <= SRC_EXT;
      dly_reg      <= '0;
      from_por_reg <= 1'b1;
      tgt_prev_reg <= 1'b0;
    end else begin
      tgt_prev_reg <= tgt_lvl;
      case (sw_reg)
        SW_RUN: begin
          if (tgt_src != cur_reg) begin
            sw_reg <= SW_LOW;
          end
        end
        SW_LOW: begin
          if (!src_lvl | fail_reg) begin
            sw_reg  <= SW_NEW;
            dly_reg <= dly_init;
          end
        end
        SW_NEW: begin
          if (tgt_ok & dly_step & (dly_reg != 4'h0)) begin
            dly_reg <= dly_reg - 4'h1;
          end else if (tgt_ok & tgt_rise & (dly_reg == 4'h0)) begin
            cur_reg      <= tgt_src;
            sw_reg       <= SW_RUN;
            from_por_reg <= 1'b0;
          end
        end
        default: sw_reg <= SW_LOW;
      endcase
      if (I_WAKE) begin
        from_por_reg <= 1'b1;
      end
    end
  end

  // System clock follows the old source until it goes low, then held low until the new source is joined
  wire sys_next = (sw_reg == SW_RUN) ? src_lvl :
                  (sw_reg == SW_LOW) ? (src_lvl & ~fail_reg) : 1'b0;
  logic sys_en_reg;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_reg    <= 1'b0;
      sys_en_reg <= 1'b0;
    end else begin
      sys_reg    <= sys_next;
      sys_en_reg <= sys_next & ~sys_reg;
    end
  end

  // ---------------------------------------------
  // Clock output pin
  // ---------------------------------------------
  logic [1:0] q_cnt_reg;
  logic       out_reg;
  wire  quarter_tick = (I_CLK_MODE == MODE_RC) ? ext_rise :
                       sys_en_reg;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q_cnt_reg <= '0;
      out_reg   <= 1'b0;
    end else if (crystal) begin
      out_reg <= ~pin_s2_reg;
    end else if (quarter_tick) begin
      q_cnt_reg <= q_cnt_reg + 2'h1;
      if (q_cnt_reg[0]) begin
        out_reg <= ~out_reg;
      end
    end
  end
  wire out_used = crystal | (I_CLK_MODE == MODE_RC) |
                  (I_CLK_MODE == MODE_INTCK);
  assign O_OSC_OUT      = out_reg;
  assign O_OSC_OUT_OE   = out_used;
  assign O_OSC_OUT_GPIO = ~out_used;
  assign O_OSC_IN_GPIO  = int_mode;
  assign O_AMP_GAIN     = crystal ? I_CLK_MODE[1:0] : 2'h0;
  assign O_SYS_CLK      = sys_reg;
  assign O_SYS_CLK_EN   = sys_en_reg;
  assign O_CPU_RUN      = ~busy_reg | I_TWO_SPEED_EN;

  // ---------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------
  logic       aw_have_reg;
  logic       w_have_reg;
  logic [3:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic       w_strb_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take  = S_AXI_WVALID & S_AXI_WREADY;
  wire do_wr   = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_ctrl = do_wr & (aw_addr_reg == OFS_CTRL) & w_strb_reg;
  wire wr_stat = do_wr & (aw_addr_reg == OFS_STAT) & w_strb_reg;
  wire wr_ok   = (aw_addr_reg == OFS_CTRL) | (aw_addr_reg == OFS_STAT);
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire boot_st = ~(I_TWO_SPEED_EN & crystal | I_FAIL_SAFE_EN);
  wire startup_timeout_status    = boot_reg ? boot_st :
                 (cur_reg == SRC_EXT) & (sw_reg == SW_RUN);
  wire [7:0] ctrl_rd = {1'b0, frq_reg, startup_timeout_status, hf_stab,
                        lf_stab, scs_reg};
  wire [7:0] stat_rd = {4'h0, busy_reg, cur_reg, fail_reg};
  wire [31:0] rd_mux = (S_AXI_ARADDR == OFS_CTRL) ? {24'h0, ctrl_rd} :
                       (S_AXI_ARADDR == OFS_STAT) ? {24'h0, stat_rd} :
                       32'h0;
  wire rd_ok   = (S_AXI_ARADDR == OFS_CTRL) | (S_AXI_ARADDR == OFS_STAT);
  assign S_AXI_AWREADY = ~aw_have_reg;
  assign S_AXI_WREADY  = ~w_have_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_strb_reg <= S_AXI_WSTRB[0];
      end
      if (do_wr) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? RESP_OK : RESP_DEC;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end else if (bvalid_reg & S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OK;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_ok ? RESP_OK : RESP_DEC;
    end else if (rvalid_reg & S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control fields; status bits are not written, except the fail bit, cleared by writing 1 to status bit 0
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      frq_reg  <= FRQ_RST;
      scs_reg  <= 1'b0;
      fail_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        frq_reg <= w_data_reg[FRQ_LO +: 3];
        scs_reg <= w_data_reg[BIT_SCS];
      end
      if (fs_trip) begin
        fail_reg <= 1'b1;
      end else if (wr_stat & w_data_reg[0]) begin
        fail_reg <= 1'b0;
      end
      if ((sw_reg == SW_RUN) & ~busy_reg & ~por_reg) begin
        boot_reg <= 1'b0;
      end
    end
  end
endmodule // occ_top

//--- occ_monitor.sv
`timescale 1ns/10ps
module occ_monitor
  import occ_pkg::*;
(
  input wire logic               I_CLK,
  input wire logic               I_RST_N,
  input wire occ_pkg::occ_mode_t I_CLK_MODE,
  input wire logic               I_TWO_SPEED_EN,
  input wire logic               I_POWER_UP_TIMER_EN,
  input wire logic               O_OSC_OUT_OE,
  input wire logic               O_OSC_IN_GPIO,
  input wire logic               O_OSC_OUT_GPIO,
  input wire logic [1:0]         O_AMP_GAIN,
  input wire logic               O_SYS_CLK_EN,
  input wire logic               O_CPU_RUN,
  input wire logic [3:0]         S_AXI_AWADDR,
  input wire logic               S_AXI_AWVALID,
  input wire logic               S_AXI_AWREADY,
  input wire logic [31:0]        S_AXI_WDATA,
  input wire logic [3:0]         S_AXI_WSTRB,
  input wire logic               S_AXI_WVALID,
  input wire logic               S_AXI_WREADY,
  input wire logic               S_AXI_BVALID,
  input wire logic [3:0]         S_AXI_ARADDR,
  input wire logic               S_AXI_ARVALID,
  input wire logic               S_AXI_ARREADY,
  input wire logic [31:0]        S_AXI_RDATA,
  input wire logic               S_AXI_RVALID
);
  import occ_pkg::*;
  // ---------------------------------------------
  // Shadow of written control fields
  // ---------------------------------------------
  logic [3:0] wa_q;
  logic [3:0] ra_q;
  logic [7:0] wd_q;
  logic       wb_q;
  logic [2:0] frq_q;
  logic       sel_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wa_q  <= 4'h0;
      ra_q  <= 4'h0;
      wd_q  <= 8'h00;
      wb_q  <= 1'b0;
      frq_q <= FRQ_RST;
      sel_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) wa_q <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd_q <= S_AXI_WDATA[7:0];
      if (S_AXI_WVALID && S_AXI_WREADY) wb_q <= S_AXI_WSTRB[0];
      if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
      if ($rose(S_AXI_BVALID) && wa_q == OFS_CTRL && wb_q) begin
        frq_q <= wd_q[6:4];
        sel_q <= wd_q[0];
      end
    end
  end
  wire xtal = I_CLK_MODE inside {MODE_LOWX, MODE_MIDX, MODE_HIGHX};
  wire ctrl_rd = S_AXI_RVALID && ra_q == OFS_CTRL;
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_ar_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_xtal_start;
    xtal && !I_TWO_SPEED_EN && !I_POWER_UP_TIMER_EN && $rose(I_RST_N);
  endsequence
  a_read_answer: assert property (s_ar_take |=> S_AXI_RVALID)
    else $error("read answer late");
  a_gain_mode: assert property (
    O_AMP_GAIN == (xtal ? I_CLK_MODE[1:0] : 2'h0))
    else $error("amplifier gain wrong");
  a_out_drive: assert property (
    O_OSC_OUT_OE == (xtal || I_CLK_MODE inside {MODE_RC, MODE_INTCK}))
    else $error("output pin drive wrong");
  a_in_free: assert property (
    O_OSC_IN_GPIO == (I_CLK_MODE inside {MODE_INTCK, MODE_INTIO}))
    else $error("input pin release wrong");
  a_out_free: assert property (
    O_OSC_OUT_GPIO == (I_CLK_MODE inside {MODE_EXT, MODE_RC_NETWORK_IO_MODE, MODE_INTIO}))
    else $error("output pin release wrong");
  a_ext_no_hold: assert property (
    I_CLK_MODE == MODE_EXT && !I_TWO_SPEED_EN |-> O_CPU_RUN)
    else $error("execution held in external mode");
  a_xtal_hold: assert property (
    s_xtal_start |-> ##[0:3] !O_CPU_RUN)
    else $error("execution not held in crystal start");
  a_bit7_zero: assert property (
    ctrl_rd |-> S_AXI_RDATA[31:7] == 25'h0)
    else $error("control upper bits not zero");
  a_freq_field: assert property (
    ctrl_rd |-> S_AXI_RDATA[6:4] == frq_q)
    else $error("frequency field wrong");
  a_sel_bit: assert property (
    ctrl_rd |-> S_AXI_RDATA[0] == sel_q)
    else $error("clock select bit wrong");
  a_en_pulse: assert property (O_SYS_CLK_EN |=> !O_SYS_CLK_EN)
    else $error("clock enable too long");
endmodule // occ_monitor
bind occ_top occ_monitor occ_monitor_i (.I_CLK, .I_RST_N, .I_CLK_MODE,
  .I_TWO_SPEED_EN, .I_POWER_UP_TIMER_EN, .O_OSC_OUT_OE, .O_OSC_IN_GPIO, .O_OSC_OUT_GPIO,
  .O_AMP_GAIN, .O_SYS_CLK_EN, .O_CPU_RUN, .S_AXI_AWADDR, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID);

//--- occ_osc_src.sv
`timescale 1ns/10ps
module occ_osc_src #(
  parameter int HALF_NS = 250
) (
  input  wire logic i_run,
  output logic      o_osc
);
  // Free-running source, stands low while stopped
  initial begin
    o_osc = 1'b0;
    forever begin
      #(HALF_NS);
      o_osc = i_run ? ~o_osc : 1'b0;
    end
  end
endmodule // occ_osc_src

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import occ_pkg::*;
  localparam int LFH = 4;
  logic I_CLK, I_RST_N, I_TWO_SPEED_EN, I_FAIL_SAFE_EN, I_POWER_UP_TIMER_EN;
  logic I_POWER_UP_TIMER_DONE, I_WAKE, I_OSC_IN, src_run, out_d;
  occ_mode_t I_CLK_MODE;
  logic O_OSC_OUT, O_OSC_OUT_OE, O_OSC_IN_GPIO, O_OSC_OUT_GPIO;
  logic O_SYS_CLK, O_SYS_CLK_EN, O_CPU_RUN;
  logic [1:0] O_AMP_GAIN, S_AXI_BRESP, S_AXI_RRESP, rs;
  logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd, rd0;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY;
  int errors, n_tests, src_rises, en_cnt, out_rises, k;
  occ_top #(.LF_HALF_CYC(LFH), .FAIL_CYC(64)) occ_top_i (.I_CLK, .I_RST_N,
    .I_CLK_MODE, .I_TWO_SPEED_EN, .I_FAIL_SAFE_EN, .I_POWER_UP_TIMER_EN, .I_POWER_UP_TIMER_DONE,
    .I_WAKE, .I_OSC_IN, .O_OSC_OUT, .O_OSC_OUT_OE, .O_OSC_IN_GPIO,
    .O_OSC_OUT_GPIO, .O_AMP_GAIN, .O_SYS_CLK, .O_SYS_CLK_EN, .O_CPU_RUN,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  occ_osc_src #(.HALF_NS(260)) occ_osc_src_i (.i_run(src_run),
    .o_osc(I_OSC_IN));
  // ---------------------------------------------
  // Clock, counters, tasks
  // ---------------------------------------------
  always #50 I_CLK = ~I_CLK;
  always @(posedge I_OSC_IN) src_rises++;
  always @(posedge I_CLK) begin
    out_d <= O_OSC_OUT;
    if (O_SYS_CLK_EN === 1'b1) en_cnt++;
    if (O_OSC_OUT === 1'b1 && out_d === 1'b0) out_rises++;
  end
  task automatic end_of_test();
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  function automatic bit near(int a, int b);
    return a >= b - 1 && a <= b + 1;
  endfunction
  task automatic meas(input int n);
    src_rises = 0;
    en_cnt = 0;
    out_rises = 0;
    repeat (n) @(posedge I_CLK);
  endtask
  task automatic do_reset(input occ_mode_t m, input logic fs);
    I_RST_N <= 1'b0;
    I_CLK_MODE <= m;
    I_FAIL_SAFE_EN <= fs;
    repeat (5) @(posedge I_CLK);
    I_RST_N <= 1'b1;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge I_CLK);
      if (!ad && S_AXI_AWREADY === 1'b1) begin
        ad = 1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!wd && S_AXI_WREADY === 1'b1) begin
        wd = 1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge I_CLK); while (S_AXI_BVALID !== 1'b1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge I_CLK);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge I_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge I_CLK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge I_CLK);
  endtask
  // ---------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------
  initial begin
    #8_000_000;
    errors++;
    end_of_test();
  end
  initial begin
    {I_CLK, I_RST_N, I_TWO_SPEED_EN, I_FAIL_SAFE_EN, I_POWER_UP_TIMER_EN} = 5'h00;
    {I_POWER_UP_TIMER_DONE, I_WAKE, S_AXI_AWVALID, S_AXI_WVALID} = 4'h0;
    {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 3'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 40'h0;
    {errors, n_tests, src_rises, en_cnt, out_rises} = '0;
    S_AXI_WSTRB = 4'hF;
    I_CLK_MODE = MODE_EXT;
    src_run = 1'b1;
    do_reset(MODE_EXT, 1'b0);
    axi_rd(OFS_CTRL, rd, rs);
    chk("freq reset", rd[6:4], FRQ_RST);
    chk("sel reset", rd[0], 1'b0);
    chk("bit7", rd[7], 1'b0);
    chk("boot status", rd[3], 1'b1);
    for (int f = 7; f >= 0; f--) begin
      axi_wr(OFS_CTRL, {25'h0, f[2:0], 4'h1}, rs);
      repeat (600) @(posedge I_CLK);
      meas(1024);
      k = f == 0 ? 1024 / (2 * LFH) : 1024 >> (8 - f);
      chk("freq rate", near(en_cnt, k), 1'b1);
      axi_rd(OFS_CTRL, rd, rs);
      chk("freq rb", rd[6:4], f[2:0]);
      chk("on internal", rd[3], 1'b0);
      chk("osc stable", f == 0 ? rd[1] : rd[2], 1'b1);
    end
    axi_wr(OFS_CTRL, 32'h0000_0060, rs);
    repeat (100) @(posedge I_CLK);
    axi_rd(OFS_CTRL, rd0, rs);
    chk("on config", rd0[3], 1'b1);
    axi_wr(OFS_CTRL, {25'h0, 3'h6, ~rd0[3:1], 1'b0}, rs);
    axi_rd(OFS_CTRL, rd, rs);
    chk("ro bits", rd[3:1], rd0[3:1]);
    S_AXI_WSTRB <= 4'h0;
    axi_wr(OFS_CTRL, 32'h0000_0071, rs);
    S_AXI_WSTRB <= 4'hF;
    axi_rd(OFS_CTRL, rd, rs);
    chk("strb off freq", rd[6:4], 3'h6);
    chk("strb off sel", rd[0], 1'b0);
    meas(400);
    chk("ext rate", near(en_cnt, src_rises), 1'b1);
    src_run <= 1'b0;
    repeat (20) @(posedge I_CLK);
    meas(200);
    chk("stopped", en_cnt, 0);
    src_run <= 1'b1;
    meas(200);
    chk("resumed", near(en_cnt, src_rises), 1'b1);
    axi_rd(4'h8, rd, rs);
    chk("unmapped rd", rd, 32'h0);
    chk("unmapped rresp", rs, RESP_DEC);
    axi_wr(4'hC, 32'h0000_0001, rs);
    chk("unmapped wr", rs, RESP_DEC);
    axi_wr(OFS_CTRL, 32'h0000_0061, rs);
    do_reset(MODE_RC, 1'b0);
    axi_rd(OFS_CTRL, rd, rs);
    chk("sel cleared", rd[0], 1'b0);
    repeat (100) @(posedge I_CLK);
    meas(400);
    chk("rc out", near(out_rises, src_rises / 4), 1'b1);
    do_reset(MODE_INTCK, 1'b0);
    repeat (200) @(posedge I_CLK);
    meas(800);
    chk("divided_clock_output", near(out_rises, en_cnt / 4), 1'b1);
    do_reset(MODE_INTIO, 1'b0);
    chk("io pins", {O_OSC_IN_GPIO, O_OSC_OUT_GPIO}, 2'h3);
    for (int m = 1; m <= 3; m++) begin
      do_reset(occ_mode_t'(m), 1'b0);
      src_rises = 0;
      repeat (4) @(posedge I_CLK);
      chk("xtal hold", O_CPU_RUN, 1'b0);
      chk("xtal gain", O_AMP_GAIN, m[1:0]);
      k = 0;
      while (O_CPU_RUN !== 1'b1 && k < 9000) begin
        @(posedge I_CLK);
        k++;
      end
      k = src_rises >= 1023 && src_rises <= 1027;
      chk("xtal count", k, 1);
    end
    I_WAKE <= 1'b1;
    @(posedge I_CLK);
    I_WAKE <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk("wake hold", O_CPU_RUN, 1'b0);
    src_run <= 1'b0;
    do_reset(MODE_EXT, 1'b1);
    axi_rd(OFS_CTRL, rd, rs);
    chk("status reset", rd[3], 1'b0);
    repeat (200) @(posedge I_CLK);
    axi_rd(OFS_STAT, rd, rs);
    chk("fail trip", rd[0], 1'b1);
    chk("fail source", rd[2:1] != 2'h0, 1'b1);
    meas(200);
    chk("fail clock", en_cnt > 0, 1'b1);
    end_of_test();
  end
endmodule // tb_top
